/* logic/hsps_pkg.sv */
/*
 * shared constants for both ends of the host serial port link:
 * strap encodings, serial timing counts, uart defaults, host register map.
 * assumes a single 25 MHz clock at each end and a bench that joins the ends.
 */
package hsps_pkg;
  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int CLK_HZ = 25000000;        // ref clock rate
  localparam int CLK_NS = 40;              // ref clock period
  localparam int SCK_CYCLE_NS = 1000;      // least serial clock cycle
  localparam int SCK_HALF_CYC = (SCK_CYCLE_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int SS_LEAD_NS = 100;         // select fall to first clock fall
  localparam int SS_LEAD_CYC = (SS_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int UART_BAUD = 9600;         // default baud rate
  localparam logic [15:0] UART_DIV_RST = 16'(CLK_HZ / UART_BAUD);
  localparam int UART_BITS = 10;           // start, 8 data, stop
  // ***************************************************************
  // host interface modes
  // ***************************************************************
  typedef enum logic [1:0] {
    HSPS_MODE_SYNC = 2'h0,
    HSPS_MODE_UART = 2'h1,
    HSPS_MODE_I2C = 2'h2,
    HSPS_MODE_NONE = 2'h3
  } hsps_mode_t;
  localparam int STRAP_W = 4;              // clock_frequency_select, oscillator_enable_strap, sel0, sel1
  localparam int STRAP_CLK = 0;
  localparam int STRAP_OSC = 1;
  localparam int STRAP_SEL0 = 2;
  localparam int STRAP_SEL1 = 3;
  localparam logic [8:0] PIN_IDLE = 9'h0E0;  // sync reset: select, clock, data idle high
  // ***************************************************************
  // host register map (word index)
  // ***************************************************************
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TXDATA = 3'h1;
  localparam logic [2:0] REG_RXDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_INT_STAT = 3'h4;
  localparam logic [2:0] REG_INT_EN = 3'h5;
  localparam logic [2:0] REG_INT_CLR = 3'h6;
  localparam int CTRL_RST_REL = 0;         // 1 releases hardware reset
  localparam int CTRL_CLOCK_FREQUENCY_SELECT = 1;
  localparam int CTRL_OSCILLATOR_ENABLE_STRAP = 2;
  localparam int CTRL_SEL0 = 3;
  localparam int CTRL_SEL1 = 4;
  localparam int CTRL_SS_N = 5;
  localparam int CTRL_STBY = 6;
  localparam logic [6:0] CTRL_RST = 7'h20; // reset held, select high
  localparam int EV_BYTE = 0;              // byte exchange done
  localparam int EV_MSG = 1;               // message ready rose
  localparam int EV_W = 2;
endpackage

/* logic/hsps_link_if.sv */
/*
 * pins between host and device.
 * assumes the data-out pin has a pull-up when nobody drives it.
 */
`timescale 1ns/10ps
interface hsps_link_if;
  logic clock_frequency_select;   // strap
  logic oscillator_enable_strap;  // strap
  logic direct_clock_input;       // held low by host
  logic oscillator_input;         // held low by host
  logic host_if_select_0;         // strap
  logic host_if_select_1;         // strap
  logic hw_reset_n;               // hardware reset, low active
  logic slave_select_n;           // select, low active
  logic sync_serial_clock;        // serial clock from host
  logic sync_serial_data_in;      // host to device, also uart rx
  logic sdo_drive;                // device value for data out
  logic sdo_oe;                   // device drives data out
  logic sync_serial_data_out;     // resolved pin level
  logic message_ready_out;        // device has a message
  logic standby_exit_in;          // host standby exit line
  // pull-up stands in for the released pin
  assign sync_serial_data_out = sdo_oe ? sdo_drive : 1'b1;
  modport dev (
    input clock_frequency_select, oscillator_enable_strap, host_if_select_0,
    input host_if_select_1, hw_reset_n, slave_select_n, sync_serial_clock,
    input sync_serial_data_in, standby_exit_in, direct_clock_input, oscillator_input,
    output sdo_drive, sdo_oe, message_ready_out
  );
  modport host (
    output clock_frequency_select, oscillator_enable_strap, host_if_select_0,
    output host_if_select_1, hw_reset_n, slave_select_n, sync_serial_clock,
    output sync_serial_data_in, standby_exit_in, direct_clock_input, oscillator_input,
    input sync_serial_data_out, message_ready_out
  );
endinterface

/* logic/hsps_device.sv */
/*
 * device end: strap capture, reset sync, synchronous slave, uart, handshakes.
 * assumes link pins are asynchronous and the i2c engine sits outside.
 */
`timescale 1ns/10ps
module hsps_device
  import hsps_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  hsps_link_if.dev link,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic msg_pending_i,
  input wire logic standby_enter_i,
  output logic standby_o,
  input wire logic uart_cfg_wr_i,
  input wire logic [15:0] uart_cfg_div_i,
  output hsps_mode_t mode_o,
  output logic fast_clock_o,
  output logic osc_source_o,
  output logic core_rst_o
);
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  localparam int PIN_W = STRAP_W + 5;
  logic [PIN_W-1:0] pin_raw, sync1_reg, sync2_reg;
  assign pin_raw = {link.standby_exit_in, link.sync_serial_data_in,
    link.sync_serial_clock, link.slave_select_n, link.hw_reset_n,
    link.host_if_select_1, link.host_if_select_0,
    link.oscillator_enable_strap, link.clock_frequency_select};
  // two flops per pin; idle reset levels keep edge detectors quiet
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= PIN_IDLE;
      sync2_reg <= PIN_IDLE;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  logic [STRAP_W-1:0] strap_s;
  logic rstn_s, ss_n_s, sck_s, sdi_s, stby_s;
  assign strap_s = sync2_reg[STRAP_W-1:0];
  assign rstn_s = sync2_reg[STRAP_W];
  assign ss_n_s = sync2_reg[STRAP_W+1];
  assign sck_s = sync2_reg[STRAP_W+2];
  assign sdi_s = sync2_reg[STRAP_W+3];
  assign stby_s = sync2_reg[STRAP_W+4];
  // ***************************************************************
  // reset and straps
  // ***************************************************************
  // internal reset follows the pin only after two synchroniser stages
  wire core_rst = rst_i | ~rstn_s;
  logic [STRAP_W-1:0] strap_reg;
  // straps follow the pins only while reset is held, then freeze
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_reg <= '0;
    end else if (~rstn_s) begin
      strap_reg <= strap_s;
    end
  end
  function automatic hsps_mode_t decode_mode(input logic [STRAP_W-1:0] s);
    hsps_mode_t m;
    m = HSPS_MODE_NONE;
    case ({s[STRAP_SEL1], s[STRAP_SEL0]})
      2'b00: m = HSPS_MODE_SYNC;
      2'b01: m = s[STRAP_CLK] ? HSPS_MODE_NONE : HSPS_MODE_UART;
      2'b10: m = HSPS_MODE_I2C;
      default: m = HSPS_MODE_NONE;
    endcase
    return m;
  endfunction
  wire hsps_mode_t mode_w = decode_mode(strap_reg);
  wire is_sync = (mode_w == HSPS_MODE_SYNC);
  wire is_uart = (mode_w == HSPS_MODE_UART);
  // ***************************************************************
  // transmit holding byte, shared by both serial modes
  // ***************************************************************
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic take_byte; // a serial engine consumes the holding byte
  wire hold_load = tx_valid_i & tx_ready_o;
  wire hold_full_next = hold_load | (hold_full_reg & ~take_byte);
  // ***************************************************************
  // synchronous slave
  // ***************************************************************
  logic sck_d_reg, ss_d_reg;
  logic [7:0] sh_tx_reg, sh_rx_reg;
  logic [2:0] bit_reg;
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;
  wire ss_fall = ~ss_n_s & ss_d_reg;
  wire sel_act = is_sync & ~ss_n_s;
  wire byte_end = sel_act & sck_rise & (bit_reg == 3'h7);
  wire [7:0] next_tx = hold_full_reg ? hold_reg : 8'hFF; // idle fill
  // ***************************************************************
  // uart engine
  // ***************************************************************
  logic [15:0] div_reg;       // baud divisor, kept until hardware reset
  logic [15:0] tx_cnt_reg, rx_cnt_reg;
  logic [3:0] tx_bits_reg, rx_bits_reg;
  logic [9:0] tx_sh_reg;
  logic [7:0] rx_sh_reg;
  wire tx_tick = (tx_cnt_reg == 16'h0000);
  wire rx_tick = (rx_cnt_reg == 16'h0000);
  wire uart_start = is_uart & (tx_bits_reg == 4'h0) & hold_full_reg;
  wire rx_start = is_uart & (rx_bits_reg == 4'h0) & ~sdi_s;
  wire rx_done = rx_tick & (rx_bits_reg == 4'h1);
  assign take_byte = uart_start | (sel_act & (ss_fall | byte_end));
  // holding register and ready flag
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      tx_ready_o <= 1'b0;
    end else if (core_rst) begin
      hold_full_reg <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      if (hold_load) begin
        hold_reg <= tx_data_i;
      end
      hold_full_reg <= hold_full_next;
      tx_ready_o <= ~hold_full_next;
    end
  end
  // synchronous slave shift logic, output enabled outside reset only: under select in sync mode, always in uart mode
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d_reg <= 1'b1;
      ss_d_reg <= 1'b1;
      sh_tx_reg <= 8'hFF;
      sh_rx_reg <= 8'h00;
      bit_reg <= 3'h0;
      link.sdo_drive <= 1'b1;
      link.sdo_oe <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      ss_d_reg <= ss_n_s;
      link.sdo_oe <= (is_sync & ~ss_n_s & ~core_rst) | (is_uart & ~core_rst);
      if (is_uart) begin
        link.sdo_drive <= tx_sh_reg[0]; // uart line shares the pin
      end else if (~sel_act) begin
        bit_reg <= 3'h0; // select high restarts the byte
      end else if (ss_fall) begin
        sh_tx_reg <= next_tx;
        link.sdo_drive <= next_tx[7];
      end else if (sck_rise) begin
        sh_rx_reg <= {sh_rx_reg[6:0], sdi_s};
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          sh_tx_reg <= next_tx;
        end
      end else if (sck_fall) begin
        if (bit_reg != 3'h0) begin
          sh_tx_reg <= {sh_tx_reg[6:0], 1'b1};
          link.sdo_drive <= sh_tx_reg[6];
        end else begin
          link.sdo_drive <= sh_tx_reg[7];
        end
      end
    end
  end
  // uart divisor: default framing on any reset, config kept otherwise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= UART_DIV_RST;
    end else if (core_rst) begin
      div_reg <= UART_DIV_RST;
    end else if (uart_cfg_wr_i) begin
      div_reg <= uart_cfg_div_i;
    end
  end
  // uart transmitter: start bit, 8 data lsb first, one stop, no parity
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt_reg <= 16'h0000;
      tx_bits_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
    end else if (core_rst) begin
      tx_bits_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
    end else if (uart_start) begin
      tx_sh_reg <= {1'b1, hold_reg, 1'b0};
      tx_bits_reg <= 4'(UART_BITS);
      tx_cnt_reg <= div_reg - 16'h0001;
    end else if (tx_bits_reg != 4'h0) begin
      tx_cnt_reg <= tx_tick ? div_reg - 16'h0001 : tx_cnt_reg - 16'h0001;
      if (tx_tick) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        tx_bits_reg <= tx_bits_reg - 4'h1;
      end
    end
  end
  // uart receiver: sample at bit centres, frame ends at stop bit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_cnt_reg <= 16'h0000;
      rx_bits_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
    end else if (core_rst) begin
      rx_bits_reg <= 4'h0;
    end else if (rx_start) begin
      rx_cnt_reg <= {1'b0, div_reg[15:1]};
      rx_bits_reg <= 4'(UART_BITS);
    end else if (rx_bits_reg != 4'h0) begin
      rx_cnt_reg <= rx_tick ? div_reg - 16'h0001 : rx_cnt_reg - 16'h0001;
      if (rx_tick) begin
        rx_bits_reg <= rx_bits_reg - 4'h1;
        if (rx_bits_reg != 4'h1 && rx_bits_reg != 4'(UART_BITS)) begin
          rx_sh_reg <= {sdi_s, rx_sh_reg[7:1]};
        end
      end
    end
  end
  // ***************************************************************
  // user side outputs and handshakes
  // ***************************************************************
  logic stby_d_reg;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      link.message_ready_out <= 1'b0;
      standby_o <= 1'b0;
      stby_d_reg <= 1'b0;
      mode_o <= HSPS_MODE_NONE;
      fast_clock_o <= 1'b0;
      osc_source_o <= 1'b0;
      core_rst_o <= 1'b1;
    end else begin
      stby_d_reg <= stby_s;
      core_rst_o <= core_rst;
      mode_o <= mode_w;
      fast_clock_o <= strap_reg[STRAP_CLK];
      osc_source_o <= strap_reg[STRAP_OSC];
      rx_valid_o <= ~core_rst & (byte_end | (rx_done & sdi_s));
      if (byte_end) begin
        rx_data_o <= {sh_rx_reg[6:0], sdi_s};
      end else if (rx_done) begin
        rx_data_o <= rx_sh_reg;
      end
      link.message_ready_out <= ~core_rst & msg_pending_i;
      if (core_rst) begin
        standby_o <= 1'b0;
      end else if (~stby_s & stby_d_reg) begin
        standby_o <= 1'b0;
      end else if (standby_enter_i) begin
        standby_o <= 1'b1;
      end
    end
  end
endmodule // hsps_device

/* logic/hsps_host.sv */
/*
 * host end: straps, reset, select, synchronous master, interrupt registers.
 * assumes software on the plain register port; uart and i2c left to the bench.
 */
`timescale 1ns/10ps
module hsps_host
  import hsps_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  hsps_link_if.host link,
  input wire logic [2:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LEAD = 2'b01,
    HS_LOW = 2'b11,
    HS_HIGH = 2'b10
  } hs_state_t;
  // ***************************************************************
  // registers and decode
  // ***************************************************************
  logic [6:0] ctrl_reg;
  logic [7:0] tx_reg, rx_reg;
  logic [EV_W-1:0] ist_reg, ien_reg;
  hs_state_t st_reg;
  logic [4:0] cnt_reg;
  logic [2:0] nbit_reg;
  logic sdo_s1_reg, sdo_s2_reg, msg_s1_reg, msg_s2_reg, msg_d_reg;
  wire wr_ctrl = wr_i & (addr_i == REG_CTRL);
  wire wr_tx = wr_i & (addr_i == REG_TXDATA);
  wire wr_clr = wr_i & (addr_i == REG_INT_CLR);
  wire wr_en = wr_i & (addr_i == REG_INT_EN);
  wire cnt_done = (cnt_reg == 5'h00);
  wire byte_done = (st_reg == HS_HIGH) & cnt_done & (nbit_reg == 3'h7);
  wire msg_rise = msg_s2_reg & ~msg_d_reg;
  wire [EV_W-1:0] ev = {msg_rise, byte_done};
  wire [31:0] status_w = {29'h0, msg_s2_reg, ctrl_reg[CTRL_SS_N], st_reg != HS_IDLE};
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_i)
      REG_CTRL: rd_mux = {25'h0, ctrl_reg};
      REG_TXDATA: rd_mux = {24'h0, tx_reg};
      REG_RXDATA: rd_mux = {24'h0, rx_reg};
      REG_STATUS: rd_mux = status_w;
      REG_INT_STAT: rd_mux = {30'h0, ist_reg};
      REG_INT_EN: rd_mux = {30'h0, ien_reg};
      default: rd_mux = 32'h0000_0000; // clear register reads zero
    endcase
  end
  // register writes, reads and sticky events; set beats clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RST;
      ist_reg <= '0;
      ien_reg <= '0;
      rdata_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      msg_s1_reg <= 1'b0;
      msg_s2_reg <= 1'b0;
      msg_d_reg <= 1'b0;
    end else begin
      msg_s1_reg <= link.message_ready_out;
      msg_s2_reg <= msg_s1_reg;
      msg_d_reg <= msg_s2_reg;
      if (wr_ctrl) begin
        ctrl_reg <= wdata_i[6:0];
      end
      if (wr_en) begin
        ien_reg <= wdata_i[EV_W-1:0];
      end
      ist_reg <= (ist_reg & ~(wr_clr ? wdata_i[EV_W-1:0] : '0)) | ev;
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
      irq_o <= |(ist_reg & ien_reg);
    end
  end
  // ***************************************************************
  // pins driven from control
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.hw_reset_n <= 1'b0;
      link.clock_frequency_select <= 1'b0;
      link.oscillator_enable_strap <= 1'b0;
      link.host_if_select_0 <= 1'b0;
      link.host_if_select_1 <= 1'b0;
      link.slave_select_n <= 1'b1;
      link.standby_exit_in <= 1'b0;
      link.direct_clock_input <= 1'b0;
      link.oscillator_input <= 1'b0;
    end else begin
      link.hw_reset_n <= ctrl_reg[CTRL_RST_REL];
      link.clock_frequency_select <= ctrl_reg[CTRL_CLOCK_FREQUENCY_SELECT];
      link.oscillator_enable_strap <= ctrl_reg[CTRL_OSCILLATOR_ENABLE_STRAP];
      link.host_if_select_0 <= ctrl_reg[CTRL_SEL0];
      link.host_if_select_1 <= ctrl_reg[CTRL_SEL1];
      link.slave_select_n <= ctrl_reg[CTRL_SS_N];
      link.standby_exit_in <= ctrl_reg[CTRL_STBY];
      link.direct_clock_input <= 1'b0;
      link.oscillator_input <= 1'b0;
    end
  end
  // ***************************************************************
  // synchronous master: clock idles high, drive on fall, sample on rise
  // ***************************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= HS_IDLE;
      cnt_reg <= 5'h00;
      nbit_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      sdo_s1_reg <= 1'b1;
      sdo_s2_reg <= 1'b1;
      link.sync_serial_clock <= 1'b1;
      link.sync_serial_data_in <= 1'b1;
    end else begin
      sdo_s1_reg <= link.sync_serial_data_out;
      sdo_s2_reg <= sdo_s1_reg;
      cnt_reg <= cnt_done ? 5'h00 : cnt_reg - 5'h01;
      case (st_reg)
        HS_IDLE: begin
          if (wr_tx) begin
            tx_reg <= wdata_i[7:0];
            nbit_reg <= 3'h0;
            cnt_reg <= 5'(SS_LEAD_CYC); // select must lead the clock
            st_reg <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (cnt_done) begin
            link.sync_serial_clock <= 1'b0;
            link.sync_serial_data_in <= tx_reg[7];
            cnt_reg <= 5'(SCK_HALF_CYC - 1);
            st_reg <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (cnt_done) begin
            link.sync_serial_clock <= 1'b1;
            rx_reg <= {rx_reg[6:0], sdo_s2_reg};
            cnt_reg <= 5'(SCK_HALF_CYC - 1);
            st_reg <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (cnt_done && nbit_reg == 3'h7) begin
            st_reg <= HS_IDLE;
          end else if (cnt_done) begin
            nbit_reg <= nbit_reg + 3'h1;
            tx_reg <= {tx_reg[6:0], 1'b1};
            link.sync_serial_clock <= 1'b0;
            link.sync_serial_data_in <= tx_reg[6];
            cnt_reg <= 5'(SCK_HALF_CYC - 1);
            st_reg <= HS_LOW;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end
endmodule // hsps_host

/* bench/hsps_checker.sv */
/* link pin checker: select gating, reset quiet time, host clock habits.
   assumes both ends share ref_clk_i and rst_i. */
`timescale 1ns/10ps
module hsps_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic direct_clock_input,
  input wire logic oscillator_input,
  input wire logic host_if_select_0,
  input wire logic host_if_select_1,
  input wire logic hw_reset_n,
  input wire logic slave_select_n,
  input wire logic sync_serial_clock,
  input wire logic sdo_oe,
  input wire logic message_ready_out
);
  // ***************************************************************
  // properties, one clock domain
  // ***************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // sync mode only: uart may drive the shared pin on its own
  wire sync_sel = !host_if_select_0 && !host_if_select_1;
  clk_pins_a: assert property (!direct_clock_input && !oscillator_input)
    else $error("clock input pins not held low");
  oe_idle_a: assert property (sync_sel && slave_select_n [*5] |-> !sdo_oe)
    else $error("data out driven with select high");
  oe_rise_a: assert property ($rose(slave_select_n) && sync_sel |-> ##[1:5] !sdo_oe)
    else $error("data out not released after select rise");
  oe_fall_a: assert property ($fell(slave_select_n) && hw_reset_n && sync_sel
    |-> ##[1:5] sdo_oe)
    else $error("data out not driven after select fall");
  sck_sel_a: assert property ($changed(sync_serial_clock) |-> !slave_select_n)
    else $error("serial clock moved outside select");
  ss_lead_a: assert property ($fell(slave_select_n) |-> sync_serial_clock [*3])
    else $error("serial clock fell too soon after select");
  rst_quiet_a: assert property (!hw_reset_n [*4] |-> !sdo_oe && !message_ready_out)
    else $error("device outputs active in reset");
  rst_sync_a: assert property ($rose(hw_reset_n) |-> !message_ready_out [*2])
    else $error("reset release not synchronised");
endmodule // hsps_checker

/* bench/tb_top.sv */
/* bench joining host and device ends over the link interface.
   assumes the design files of logic/ are compiled first. */
`timescale 1ns/10ps
module tb_top
  import hsps_pkg::*;
;
  // ***************************************************************
  // stimulus and observed signals
  // ***************************************************************
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic wr = 1'b0, rd = 1'b0, irq, tx_ready, rx_valid, standby, fast, osc, core_rst;
  logic tx_valid = 1'b0, msg_pend = 1'b0, stby_in = 1'b0, cfg_wr = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data, rx_last, so_sh, si_sh;
  logic [15:0] cfg_div = 16'h0000;
  logic [31:0] mtab [5] = '{32'h20, 32'h2C, 32'h30, 32'h3C, 32'h2A}; // strap sets
  hsps_mode_t mode;
  int failures = 0, comparisons = 0, n;
  hsps_link_if link ();
  always #20 ref_clk_i = ~ref_clk_i;
  hsps_host hsps_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link.host),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
  hsps_device hsps_device_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link.dev),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .msg_pending_i(msg_pend), .standby_enter_i(stby_in),
    .standby_o(standby), .uart_cfg_wr_i(cfg_wr), .uart_cfg_div_i(cfg_div), .mode_o(mode),
    .fast_clock_o(fast), .osc_source_o(osc), .core_rst_o(core_rst));
  hsps_checker hsps_checker_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .direct_clock_input(link.direct_clock_input), .oscillator_input(link.oscillator_input),
    .host_if_select_0(link.host_if_select_0), .host_if_select_1(link.host_if_select_1),
    .hw_reset_n(link.hw_reset_n), .slave_select_n(link.slave_select_n),
    .sync_serial_clock(link.sync_serial_clock), .sdo_oe(link.sdo_oe),
    .message_ready_out(link.message_ready_out));
  // wire-level shifters: bit order is judged on the pins themselves
  always @(posedge link.sync_serial_clock) if (link.slave_select_n === 1'b0) begin
    so_sh <= {so_sh[6:0], link.sync_serial_data_out};
    si_sh <= {si_sh[6:0], link.sync_serial_data_in};
  end
  always @(posedge ref_clk_i) if (rx_valid === 1'b1) rx_last <= rx_data;
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe low for a cycle after each access, so no double drive per step
  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i) wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i) rd <= 1'b0;
    @(posedge ref_clk_i) v = rdata;
    chk(nm, v & m, e);
  endtask
  // straps only count while the device sits in hardware reset
  task automatic cfg(input logic [31:0] c);
    wreg(REG_CTRL, c);
    repeat (6) @(posedge ref_clk_i);
    wreg(REG_CTRL, c | 32'h1);
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic xfer(input logic [7:0] b);
    wreg(REG_TXDATA, {24'h0, b});
    n = 0;
    v = 32'h1;
    while (v[0] !== 1'b0 && n < 300) begin
      rchk(REG_STATUS, 32'h2, 32'h0, "status");
      n++;
    end
    chk("xfer done", {31'h0, v[0]}, 32'h0);
  endtask
  // start bit then a one: low time equals one bit time
  task automatic ubit(input logic [15:0] d);
    tx_data <= 8'h55;
    tx_valid <= 1'b1;
    @(posedge ref_clk_i) tx_valid <= 1'b0;
    for (n = 0; link.sync_serial_data_out !== 1'b0 && n < 100; n++) @(posedge ref_clk_i);
    for (n = 0; link.sync_serial_data_out !== 1'b1 && n < 5000; n++) @(posedge ref_clk_i);
    chk("bit time", 32'(n), {16'h0, d});
    repeat (10 * d) @(posedge ref_clk_i);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rchk(REG_CTRL, 32'h7F, {25'h0, CTRL_RST}, "ctrl reset");
    rchk(3'h7, 32'hFFFFFFFF, 32'h0, "unmapped");
    for (int i = 0; i < 5; i++) begin
      cfg(mtab[i]);
      chk("mode", 32'(mode), (i < 4) ? i : 3);
      chk("osc", 32'(osc), {31'h0, mtab[i][2]});
      chk("fast", 32'(fast), {31'h0, mtab[i][1]});
      chk("core reset", {31'h0, core_rst}, 32'h0);
      // flip the clock and select straps while hardware reset stays released
      wreg(REG_CTRL, (mtab[i] ^ 32'h1A) | 32'h1);
      repeat (4) @(posedge ref_clk_i);
      chk("held mode", 32'(mode), (i < 4) ? i : 3);
    end
    cfg(32'h20);
    tx_data <= 8'hA5;
    tx_valid <= 1'b1;
    @(posedge ref_clk_i) tx_valid <= 1'b0;
    chk("tx ready", {31'h0, tx_ready}, 32'h1);
    wreg(REG_CTRL, 32'h01);
    xfer(8'h3C);
    chk("dev rx", {24'h0, rx_last}, 32'h3C);
    chk("wire in", {24'h0, si_sh}, 32'h3C);
    chk("wire out", {24'h0, so_sh}, 32'hA5);
    rchk(REG_RXDATA, 32'hFF, 32'hA5, "host rx");
    rchk(REG_INT_STAT, 32'h1, 32'h1, "byte event");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wreg(REG_INT_EN, 32'h1);
    @(posedge ref_clk_i);
    chk("irq on", {31'h0, irq}, 32'h1);
    wreg(REG_INT_CLR, 32'h1);
    @(posedge ref_clk_i);
    chk("irq clear", {31'h0, irq}, 32'h0);
    xfer(8'h81);
    rchk(REG_RXDATA, 32'hFF, 32'hFF, "idle fill");
    chk("dev rx2", {24'h0, rx_last}, 32'h81);
    wreg(REG_CTRL, 32'h21);
    repeat (6) @(posedge ref_clk_i);
    chk("released", {31'h0, link.sdo_oe}, 32'h0);
    msg_pend <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk("msg pin", {31'h0, link.message_ready_out}, 32'h1);
    rchk(REG_INT_STAT, 32'h2, 32'h2, "msg event");
    stby_in <= 1'b1;
    @(posedge ref_clk_i) stby_in <= 1'b0;
    @(posedge ref_clk_i);
    chk("standby", {31'h0, standby}, 32'h1);
    wreg(REG_CTRL, 32'h61);
    wreg(REG_CTRL, 32'h21);
    repeat (8) @(posedge ref_clk_i);
    chk("woken", {31'h0, standby}, 32'h0);
    cfg(32'h28);
    ubit(UART_DIV_RST);
    cfg_div <= 16'h0010;
    cfg_wr <= 1'b1;
    @(posedge ref_clk_i) cfg_wr <= 1'b0;
    ubit(16'h0010);
    cfg(32'h28);
    ubit(UART_DIV_RST);
    wrap_up();
  end
  // watchdog: the run needs some 60000 cycles
  initial begin
    #4000000;
    failures++;
    wrap_up();
  end
endmodule // tb_top
